/* File: core/timer_unit_clock_prescaler.v */
/*
 * Clock gate, prescaler and per-channel operation clock selection for a
 * four-channel timer unit, with the four channel mode registers.
 * Assumes a CPU-style register port on the system clock, timer inputs
 * asynchronous to it, and channel counters that consume the enables.
 */

`include "timer_clock_defines.vh"

module timer_unit_clock_prescaler (
	// Clock and reset
	input wire I_CLK_SYS,
	input wire I_SRST,
	// Register port
	input wire [19:0] I_ADDR,
	input wire I_WR,
	input wire I_RD,
	input wire [1:0] I_SIZE,
	input wire [2:0] I_BIT,
	input wire [15:0] I_WDATA,
	output reg [15:0] O_RDATA,
	output reg O_RVALID,
	// Timer input pins
	input wire [3:0] I_TIN,
	// Unit state
	output reg O_UNIT_EN,
	output reg O_UNIT_RESET,
	// Prescaled clocks a, b, c, d as one-cycle enables
	output reg [3:0] O_PRE_TICK,
	// Per-channel clocks
	output reg [3:0] O_OP_CLK,
	output reg [3:0] O_COUNT_CLK,
	output reg [3:0] O_EDGE,
	// Per-channel mode decode
	output reg [3:0] O_SPLIT,
	output reg O_LEADER,
	output reg [3:0] O_SETUP_ERR,
	output reg [15:0] O_MODE0,
	output reg [15:0] O_MODE1,
	output reg [15:0] O_MODE2,
	output reg [15:0] O_MODE3
);

	// ------------------------------------------------------------------
	// Divider helpers
	// ------------------------------------------------------------------

	// True on the last cycle of every 2^k cycles of the divider.
	function div_tick;
		input [14:0] cnt;
		input [3:0] k;
		reg [14:0] m;
		begin
			m = ~(15'h7FFF << k);
			div_tick = &(cnt | ~m);
		end
	endfunction

	// Exponent of the third clock from its 2-bit code.
	function [3:0] exp_c;
		input [1:0] code;
		begin
			case (code)
				2'h0: exp_c = 4'h1;
				2'h1: exp_c = 4'h2;
				2'h2: exp_c = 4'h4;
				default: exp_c = 4'h6;
			endcase
		end
	endfunction

	// Exponent of the fourth clock from its 2-bit code.
	function [3:0] exp_d;
		input [1:0] code;
		begin
			case (code)
				2'h0: exp_d = 4'h8;
				2'h1: exp_d = 4'hA;
				2'h2: exp_d = 4'hC;
				default: exp_d = 4'hE;
			endcase
		end
	endfunction

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	reg gate_q;
	reg [15:0] tps_q;
	reg [15:0] mode_q [0:3];
	reg [14:0] div_q;
	reg [3:0] tick_q;
	reg [3:0] tin_s1_q;
	reg [3:0] tin_s2_q;
	reg [3:0] smp_q;
	reg [15:0] rdata_d;
	wire [3:0] op_w;
	wire [3:0] edge_w;
	wire [3:0] count_w;
	wire [3:0] err_w;
	wire [3:0] mode_hit;
	wire word_wr;
	wire [3:0] tick_d;
	wire [3:0] mask_bit11;

	assign word_wr = I_WR && (I_SIZE == `SIZE_WORD);
	assign mode_hit[0] = word_wr && (I_ADDR == `ADDR_MODE0);
	assign mode_hit[1] = word_wr && (I_ADDR == `ADDR_MODE1);
	assign mode_hit[2] = word_wr && (I_ADDR == `ADDR_MODE2);
	assign mode_hit[3] = word_wr && (I_ADDR == `ADDR_MODE3);
	assign mask_bit11 = 4'hE;

	// ------------------------------------------------------------------
	// Clock gate register
	// ------------------------------------------------------------------

	always @(posedge I_CLK_SYS)
	begin
		if (I_SRST)
			gate_q <= `GATE_RESET;
		else if (I_WR && (I_ADDR == `ADDR_CLOCK_GATE) &&
			((I_SIZE == `SIZE_BYTE) ||
			((I_SIZE == `SIZE_BIT) && (I_BIT == `GATE_BIT))))
			gate_q <= I_WDATA[0];
	end

	// ------------------------------------------------------------------
	// Prescaler select register
	// ------------------------------------------------------------------

	always @(posedge I_CLK_SYS)
	begin
		if (I_SRST || !gate_q)
			tps_q <= `PRESCALE_RESET;
		else if (word_wr && (I_ADDR == `ADDR_PRESCALE))
			tps_q <= I_WDATA & `PRESCALE_MASK;
	end

	// ------------------------------------------------------------------
	// Prescaler divider
	// ------------------------------------------------------------------

	always @(posedge I_CLK_SYS)
	begin
		if (I_SRST || !gate_q)
			div_q <= 15'h0000;
		else
			div_q <= div_q + 15'h0001;
	end

	assign tick_d[0] = div_tick(div_q, tps_q[`PRE_A_LSB+3:`PRE_A_LSB]);
	assign tick_d[1] = div_tick(div_q, tps_q[`PRE_B_LSB+3:`PRE_B_LSB]);
	assign tick_d[2] = div_tick(div_q,
		exp_c(tps_q[`PRE_C_LSB+1:`PRE_C_LSB]));
	assign tick_d[3] = div_tick(div_q,
		exp_d(tps_q[`PRE_D_LSB+1:`PRE_D_LSB]));

	always @(posedge I_CLK_SYS)
	begin
		if (I_SRST || !gate_q)
			tick_q <= 4'h0;
		else
			tick_q <= tick_d;
	end

	// ------------------------------------------------------------------
	// Timer input synchronisers
	// ------------------------------------------------------------------
	always @(posedge I_CLK_SYS)
	begin
		if (I_SRST)
		begin
			tin_s1_q <= 4'h0;
			tin_s2_q <= 4'h0;
		end
		else
		begin
			tin_s1_q <= I_TIN;
			tin_s2_q <= tin_s1_q;
		end
	end

	// ------------------------------------------------------------------
	// Channel mode registers and clock selection
	// ------------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1)
		begin : chan
			localparam CD_OK = (g == 1) || (g == 3);
			wire [1:0] sel;
			wire [1:0] cis;
			wire [2:0] sts;
			wire [3:0] md;
			wire [15:0] wmask;
			wire trig_bad;
			wire md_bad;

			assign sel = mode_q[g][`OPSEL_LSB+1:`OPSEL_LSB];
			assign cis = mode_q[g][`EDGE_LSB+1:`EDGE_LSB];
			assign sts = mode_q[g][`TRIG_LSB+2:`TRIG_LSB];
			assign md = mode_q[g][`OPMODE_LSB+3:`OPMODE_LSB];
			// bit 11 fixed zero on channel 0
			assign wmask = mask_bit11[g] ? `MODE_MASK_CHX :
				`MODE_MASK_CH0;

			always @(posedge I_CLK_SYS)
			begin
				if (I_SRST || !gate_q)
					mode_q[g] <= `MODE_RESET;
				else if (mode_hit[g])
					mode_q[g] <= I_WDATA & wmask;
			end

			// c and d on 1, 3 only
			assign op_w[g] = (sel == `OPSEL_A) ? tick_q[0] :
				(sel == `OPSEL_B) ? tick_q[1] :
				(sel == `OPSEL_C) ? (CD_OK && tick_q[2]) :
				(CD_OK && tick_q[3]);

			always @(posedge I_CLK_SYS)
			begin
				if (I_SRST || !gate_q)
					smp_q[g] <= 1'b0;
				else if (op_w[g])
					smp_q[g] <= tin_s2_q[g];
			end

			assign edge_w[g] = op_w[g] && (
				(cis == 2'h0) ? (smp_q[g] && !tin_s2_q[g]) :
				(cis == 2'h1) ? (!smp_q[g] && tin_s2_q[g]) :
				(smp_q[g] ^ tin_s2_q[g]));

			assign count_w[g] = mode_q[g][`CCS_BIT] ? edge_w[g] : op_w[g];

			// Flags prohibited trigger, mode or clock codes.
			assign trig_bad = (sts == 3'h3) || (sts[2] && (sts[1:0] != 2'h0));
			assign md_bad = (md[3:1] == 3'h1) || (md[3:1] == 3'h5) ||
				(md[3:1] == 3'h7) || (md == 4'h7) || (md == 4'hD);
			assign err_w[g] = trig_bad || md_bad ||
				(!CD_OK && sel[0]);
		end
	endgenerate

	// ------------------------------------------------------------------
	// Register read port
	// ------------------------------------------------------------------
	always @*
	begin
		rdata_d = 16'h0000;
		case (I_ADDR)
			`ADDR_CLOCK_GATE: rdata_d = {15'h0000, gate_q};
			`ADDR_PRESCALE: rdata_d = tps_q;
			`ADDR_MODE0: rdata_d = mode_q[0];
			`ADDR_MODE1: rdata_d = mode_q[1];
			`ADDR_MODE2: rdata_d = mode_q[2];
			`ADDR_MODE3: rdata_d = mode_q[3];
			default: rdata_d = 16'h0000;
		endcase
	end

	always @(posedge I_CLK_SYS)
	begin
		if (I_SRST)
		begin
			O_RDATA <= 16'h0000;
			O_RVALID <= 1'b0;
		end
		else
		begin
			O_RVALID <= I_RD;
			if (I_RD)
				O_RDATA <= rdata_d;
		end
	end

	// ------------------------------------------------------------------
	// Output registers
	// ------------------------------------------------------------------
	always @(posedge I_CLK_SYS)
	begin
		if (I_SRST)
		begin
			O_UNIT_EN <= 1'b0;
			O_UNIT_RESET <= 1'b1;
			O_PRE_TICK <= 4'h0;
			O_OP_CLK <= 4'h0;
			O_COUNT_CLK <= 4'h0;
			O_EDGE <= 4'h0;
			O_SPLIT <= 4'h0;
			O_LEADER <= 1'b0;
			O_SETUP_ERR <= 4'h0;
			O_MODE0 <= `MODE_RESET;
			O_MODE1 <= `MODE_RESET;
			O_MODE2 <= `MODE_RESET;
			O_MODE3 <= `MODE_RESET;
		end
		else
		begin
			// unit live only with gate set
			O_UNIT_EN <= gate_q;
			O_UNIT_RESET <= !gate_q;
			O_PRE_TICK <= tick_q;
			O_OP_CLK <= op_w;
			O_COUNT_CLK <= count_w;
			O_EDGE <= edge_w;
			O_SPLIT <= {mode_q[3][`BIT11], 1'b0, mode_q[1][`BIT11], 1'b0};
			O_LEADER <= mode_q[2][`BIT11];
			O_SETUP_ERR <= err_w;
			O_MODE0 <= mode_q[0];
			O_MODE1 <= mode_q[1];
			O_MODE2 <= mode_q[2];
			O_MODE3 <= mode_q[3];
		end
	end

endmodule // timer_unit_clock_prescaler

/* File: include/timer_clock_defines.vh */
/*
 * Constants for the timer unit clock gate, prescaler and channel mode
 * registers: addresses, access sizes, field positions, masks and resets.
 * Assumes a 20-bit CPU address and a 16-bit data path.
 */
`ifndef TIMER_CLOCK_DEFINES_VH
`define TIMER_CLOCK_DEFINES_VH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define ADDR_CLOCK_GATE 20'hF00F0
`define ADDR_MODE0 20'hF0190
`define ADDR_MODE1 20'hF0192
`define ADDR_MODE2 20'hF0194
`define ADDR_MODE3 20'hF0196
`define ADDR_PRESCALE 20'hF01B6

// ----------------------------------------------------------------------
// Access sizes
// ----------------------------------------------------------------------
`define SIZE_BIT 2'h0
`define SIZE_BYTE 2'h1
`define SIZE_WORD 2'h2

// ----------------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------------
`define GATE_RESET 1'h0
`define PRESCALE_RESET 16'h0000
`define MODE_RESET 16'h0000
`define PRESCALE_MASK 16'h33FF
`define MODE_MASK_CH0 16'hD7CF
`define MODE_MASK_CHX 16'hDFCF

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define GATE_BIT 3'h0
`define PRE_A_LSB 0
`define PRE_B_LSB 4
`define PRE_C_LSB 8
`define PRE_D_LSB 12
`define OPSEL_LSB 14
`define CCS_BIT 12
`define BIT11 11
`define TRIG_LSB 8
`define EDGE_LSB 6
`define OPMODE_LSB 0

// ----------------------------------------------------------------------
// Operation clock select codes and divider width
// ----------------------------------------------------------------------
`define OPSEL_A 2'h0
`define OPSEL_C 2'h1
`define OPSEL_B 2'h2
`define OPSEL_D 2'h3
`define DIV_WIDTH 15

`endif

/* File: dv/timer_clock_checker.sv */
/*
 * Port checker for the timer clock prescaler.
 * Assumes it is bound to the design and sees only its ports.
 */
module timer_clock_checker (
	input logic I_CLK_SYS,
	input logic I_SRST,
	input logic O_UNIT_RESET,
	input logic O_LEADER,
	input logic [3:0] O_PRE_TICK,
	input logic [3:0] O_OP_CLK,
	input logic [3:0] O_COUNT_CLK,
	input logic [3:0] O_EDGE,
	input logic [3:0] O_SPLIT,
	input logic [15:0] O_MODE0,
	input logic [15:0] O_MODE1,
	input logic [15:0] O_MODE2,
	input logic [15:0] O_MODE3
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----
	// Properties
	// ----
	default clocking cb @(posedge I_CLK_SYS);
	endclocking
	default disable iff (I_SRST);
	AST_GATE_OFF: assert property (O_UNIT_RESET [*4] |-> !O_PRE_TICK)
		else $error("tick while unit held off");
	AST_C_PULSE: assert property (O_PRE_TICK[2] |=> !O_PRE_TICK[2])
		else $error("clock c pulse too wide");
	AST_D_GAP: assert property (O_PRE_TICK[3] |=> !O_PRE_TICK[3] [*8])
		else $error("clock d pulses too close");
	AST_D_ON_C: assert property (O_PRE_TICK[3] |-> O_PRE_TICK[2])
		else $error("clock d not aligned to clock c");
	AST_CH0_NO_CD: assert property (O_MODE0[14] && $stable(O_MODE0)
		|-> !O_OP_CLK[0]) else $error("channel 0 got clock c or d");
	AST_CH1_SEL: assert property (O_MODE1[15:14] == 2'h1
		&& $stable(O_MODE1) |-> O_OP_CLK[1] == O_PRE_TICK[2])
		else $error("channel 1 select code 01 wrong");
	AST_CH2_SEL: assert property (O_MODE2[15:14] == 2'h2
		&& $stable(O_MODE2) |-> O_OP_CLK[2] == O_PRE_TICK[1])
		else $error("channel 2 select code 10 wrong");
	AST_CH3_SEL: assert property (O_MODE3[15:14] == 2'h3
		&& $stable(O_MODE3) |-> O_OP_CLK[3] == O_PRE_TICK[3])
		else $error("channel 3 select code 11 wrong");
	AST_COUNT_SEL: assert property ($stable(O_MODE1) |-> O_COUNT_CLK[1]
		== (O_MODE1[12] ? O_EDGE[1] : O_OP_CLK[1]))
		else $error("channel 1 count clock wrong");
	AST_RSVD: assert property ((O_MODE0 & 16'h2830) == 16'h0000)
		else $error("reserved mode bits set");
	AST_BIT11: assert property ($stable(O_MODE1) && $stable(O_MODE3)
		&& $stable(O_MODE2) |-> O_LEADER == O_MODE2[11]
		&& O_SPLIT == {O_MODE3[11], 1'b0, O_MODE1[11], 1'b0})
		else $error("bit 11 decode wrong");
endmodule // timer_clock_checker

bind timer_unit_clock_prescaler timer_clock_checker chk_u (
	.I_CLK_SYS(I_CLK_SYS), .I_SRST(I_SRST), .O_UNIT_RESET(O_UNIT_RESET),
	.O_LEADER(O_LEADER), .O_PRE_TICK(O_PRE_TICK), .O_OP_CLK(O_OP_CLK),
	.O_COUNT_CLK(O_COUNT_CLK), .O_EDGE(O_EDGE), .O_SPLIT(O_SPLIT),
	.O_MODE0(O_MODE0), .O_MODE1(O_MODE1), .O_MODE2(O_MODE2),
	.O_MODE3(O_MODE3)
);

/* File: dv/test_timer_unit_clock_prescaler.sv */
/*
 * Register-level bench for the timer clock prescaler.
 * Assumes the design's one-cycle strobes and one-cycle read latency.
 */
`include "timer_clock_defines.vh"
module test_timer_unit_clock_prescaler;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [19:0] addr = 20'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [1:0] size = 2'h0;
	logic [2:0] bitn = 3'h0;
	logic [15:0] wdata = 16'h0;
	logic [3:0] tin = 4'h0;
	wire [15:0] rdata;
	wire rvalid, unit_en, leader;
	wire [3:0] tick, cntclk, split, serr;
	int bad_count = 0;
	int samples_checked = 0;
	int n;
	int ac [4] = '{0, 1, 5, 12};
	int bc [4] = '{2, 4, 8, 13};
	int cc [4] = '{2, 4, 16, 64};
	timer_unit_clock_prescaler dut_u (
		.I_CLK_SYS(clk), .I_SRST(srst), .I_ADDR(addr), .I_WR(wr),
		.I_RD(rd), .I_SIZE(size), .I_BIT(bitn), .I_WDATA(wdata),
		.O_RDATA(rdata), .O_RVALID(rvalid), .I_TIN(tin),
		.O_UNIT_EN(unit_en), .O_UNIT_RESET(), .O_PRE_TICK(tick),
		.O_OP_CLK(), .O_COUNT_CLK(cntclk), .O_EDGE(), .O_SPLIT(split),
		.O_LEADER(leader), .O_SETUP_ERR(serr), .O_MODE0(), .O_MODE1(),
		.O_MODE2(), .O_MODE3()
	);
	// ----
	// Tasks
	// ----
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wrr(input logic [19:0] a, input logic [1:0] s,
		input logic [2:0] b, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		size <= s;
		bitn <= b;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rdc(input logic [19:0] a, input logic [15:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk({15'h0, rvalid}, 16'h0001);
		chk(rdata, exp);
	endtask
	// Cycles between two rises of one tick, stale ticks skipped.
	task automatic per(input int i, input int e);
		repeat (4) @(posedge clk);
		n = 0;
		while (tick[i] !== 1'b1 && n < 40000)
		begin
			@(posedge clk);
			n++;
		end
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end while (tick[i] !== 1'b1 && n < 40000);
		chk(n[15:0], e[15:0]);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ----
	// Sequence
	// ----
	initial
	begin
		forever #12.5 clk = ~clk;
	end
	initial
	begin
		repeat (95000) @(posedge clk);
		bad_count++;
		tally_and_finish;
	end
	initial
	begin
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		rdc(`ADDR_CLOCK_GATE, 16'h0000);
		wrr(`ADDR_PRESCALE, `SIZE_WORD, 3'h0, 16'h0011);
		rdc(`ADDR_PRESCALE, 16'h0000);
		wrr(`ADDR_CLOCK_GATE, `SIZE_BIT, 3'h0, 16'h0001);
		rdc(`ADDR_CLOCK_GATE, 16'h0001);
		chk({15'h0, unit_en}, 16'h0001);
		wrr(`ADDR_PRESCALE, `SIZE_BYTE, 3'h0, 16'h0003);
		rdc(`ADDR_PRESCALE, 16'h0000);
		wrr(`ADDR_PRESCALE, `SIZE_WORD, 3'h0, 16'hFFFF);
		rdc(`ADDR_PRESCALE, 16'h33FF);
		wrr(`ADDR_MODE0, `SIZE_WORD, 3'h0, 16'hFFFF);
		rdc(`ADDR_MODE0, 16'hD7CF);
		wrr(`ADDR_MODE1, `SIZE_WORD, 3'h0, 16'hFFFF);
		rdc(`ADDR_MODE1, 16'hDFCF);
		chk({12'h0, split}, 16'h0002);
		wrr(`ADDR_MODE2, `SIZE_BYTE, 3'h0, 16'h0800);
		rdc(`ADDR_MODE2, 16'h0000);
		wrr(`ADDR_MODE2, `SIZE_WORD, 3'h0, 16'h8800);
		rdc(20'hF0198, 16'h0000);
		chk({15'h0, leader}, 16'h0001);
		wrr(`ADDR_MODE0, `SIZE_WORD, 3'h0, 16'h4000);
		wrr(`ADDR_MODE1, `SIZE_WORD, 3'h0, 16'h4000);
		wrr(`ADDR_MODE3, `SIZE_WORD, 3'h0, 16'hC000);
		@(posedge clk);
		#1;
		chk({12'h0, serr}, 16'h0001);
		for (int i = 0; i < 4; i++)
		begin
			wrr(`ADDR_PRESCALE, `SIZE_WORD, 3'h0, {2'h0, i[1:0], 2'h0,
				i[1:0], bc[i][3:0], ac[i][3:0]});
			per(0, 1 << ac[i]);
			per(1, 1 << bc[i]);
			per(2, cc[i]);
			per(3, 1 << (8 + 2 * i));
		end
		wrr(`ADDR_PRESCALE, `SIZE_WORD, 3'h0, 16'h0000);
		wrr(`ADDR_MODE1, `SIZE_WORD, 3'h0, 16'h1040);
		repeat (4) @(posedge clk);
		for (int v = 1; v >= 0; v--)
		begin
			tin[1] <= v[0];
			n = 0;
			repeat (20)
			begin
				@(posedge clk);
				if (cntclk[1] === 1'b1)
					n++;
			end
			chk(n[15:0], v[15:0]);
		end
		wrr(`ADDR_CLOCK_GATE, `SIZE_BYTE, 3'h0, 16'h0000);
		rdc(`ADDR_MODE1, 16'h0000);
		wrr(`ADDR_MODE3, `SIZE_WORD, 3'h0, 16'h4000);
		rdc(`ADDR_MODE3, 16'h0000);
		repeat (8) @(posedge clk);
		chk({12'h0, tick}, 16'h0000);
		tally_and_finish;
	end
endmodule // test_timer_unit_clock_prescaler
